// [verilog/adc_tp_defines.svh]
`ifndef ADC_TP_DEFINES_SVH
`define ADC_TP_DEFINES_SVH

// Register addresses on the serial register port.
`define ADDR_CONTROL       5'h01
`define ADDR_TEST_PATTERN  5'h05
`define ADDR_STARTUP_DELAY 5'h06
`define ADDR_BANK_SELECT   5'h0F
`define ADDR_BANK_FIRST    5'h10

// Field positions.
`define CTRL_TEST_EN_BIT   12
`define TP_KIND_BIT        0
`define TP_FLASH_LSB       1

// Reset values.
`define RST_PATTERN_KIND   1'h0
`define RST_FLASH_SEL      2'h0
`define RST_STARTUP_DELAY  4'h0
`define RST_BANK_SELECT    3'h0

// Pattern constants.
`define RAMP_MAX           11'h7FF
`define FLASH_HIGH_WORD    11'h7FF
`define FLASH_PERIOD_11    4'hA
`define FLASH_PERIOD_12    4'hB
`define FLASH_PERIOD_16    4'hF

`endif

// [verilog/adc_tp_pkg.sv]
package adc_tp_pkg;

  // Start-up sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } seq_state_t;

  // Four cores, eleven bits each: out-of-range bit on top of ten data bits.
  typedef logic [3:0][10:0] core_words_t;

  // Register port request from the serial interface decoder.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Whole state of the block.
  typedef struct packed {
    logic              test_en;
    logic              pattern_kind_sel;
    logic [1:0]        flash_period_sel;
    logic [3:0]        startup_delay;
    logic [2:0]        bank_sel;
    logic [3:0][15:0]  bank_regs;
    logic [15:0]       rdata;
    logic [1:0]        adc_rst_sync;
    logic [1:0][1:0]   sync_sync;   // Per stage: positive leg, negative leg.
    logic              sync_prev;
    seq_state_t        state;
    logic [3:0]        delay_cnt;
    logic [10:0]       ramp;
    logic [3:0]        flash_cnt;
    core_words_t       samples;
  } tp_state_t;

endpackage

// [verilog/adc_test_pattern_and_channel_select.sv]
`include "adc_tp_defines.svh"

// What this block does
// [R1] Ramp mode drives 0..2047 on all cores.
// [R2] Kind selector one picks the flashing pattern.
// [R3] Flash period codes give 11, 12, 16 words.
// [R4] Ones word, then zeros, repeating each period.
// [R5] Reset gives period-11 code and ramp kind.
// [R6] Pattern kind honoured only with test-enable set.
// [R7] Host drives sync input during test output.
// [R8] Patterns are 11 bits; flash high is 7FF.
// [R9] Ramp outputs hold their value during reset.
// [R10] Ramp is binary, plus one, wraps to zero.
// [R11] Start-up waits n extra clocks, reset zero.
// [R12] With reset-mode set, host avoids delay zero.
// [R13] Selector codes 001, 011, 100 pick A, C, D.
// [R14] Code 000 and undefined codes select nothing.
// [R15] Host sets selector before per-core accesses.
// [R16] Selector code 010 picks core B.
// [R17] Per-core register is banked four ways.
module adc_test_pattern_and_channel_select
  import adc_tp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port from the serial interface decoder.
  input  wire reg_req_t    reg_req,
  output      logic [15:0] reg_rdata,
  // Converter master reset, synchronization pins and reset-mode flag.
  input  wire logic        adc_reset_in,
  input  wire logic        sync_pos_in,
  input  wire logic        sync_neg_in,
  input  wire logic        reset_mode_flag,
  // Converted samples in, selected samples out.
  input  wire core_words_t conv_words,
  output      core_words_t out_words,
  // Observable control state.
  output      logic [3:0]  core_selected,
  output      logic        started_up
);

  tp_state_t st_ff;      // Every flip-flop of the block.
  tp_state_t nxt_st;     // Next value of the whole state.
  logic [2:0] bank_idx;  // Decoded bank index, bit 2 marks a valid selection.
  logic       sync_rise; // Rising edge of the synchronized sync input.
  logic [10:0] pattern;  // Current test word, common to all cores.
  logic [3:0] flash_end; // Last count of the chosen flash period.

  // Map the selector code to a bank; anything but 001..100 selects no core.
  function automatic logic [2:0] decode_bank(input logic [2:0] code);
    case (code)
      3'h1:    decode_bank = 3'h4; // [R13]
      3'h2:    decode_bank = 3'h5; // [R16]
      3'h3:    decode_bank = 3'h6; // [R13]
      3'h4:    decode_bank = 3'h7; // [R13]
      default: decode_bank = 3'h0; // [R14]
    endcase
  endfunction

  // Selector decode is shared between writes, reads and the core flags.
  assign bank_idx = decode_bank(st_ff.bank_sel);

  // Only the second synchronizer stage is looked at for the edge; the two legs
  // are combined only after both have crossed, so no gate sits before a synchronizer flop.
  assign sync_rise = st_ff.sync_sync[1][1] & ~st_ff.sync_sync[1][0] & ~st_ff.sync_prev;

  // Flash period: one high word then 10, 11 or 15 zero words.
  always_comb begin
    case (st_ff.flash_period_sel)
      2'h1:    flash_end = `FLASH_PERIOD_12; // [R3]
      2'h2:    flash_end = `FLASH_PERIOD_16; // [R3]
      default: flash_end = `FLASH_PERIOD_11; // [R3]
    endcase
  end

  // Pattern word; flash high is all eleven bits, ramp is the counter itself.
  always_comb begin
    if (st_ff.pattern_kind_sel) begin
      pattern = (st_ff.flash_cnt == 4'h0) ? `FLASH_HIGH_WORD : 11'h000; // [R2] [R4] [R8]
    end else begin
      pattern = st_ff.ramp; // [R1] [R8]
    end
  end

  // All next-state logic of the block.
  always_comb begin
    nxt_st = st_ff;

    // Two-flop synchronizers for the pins from outside the clock domain.
    nxt_st.adc_rst_sync = {st_ff.adc_rst_sync[0], adc_reset_in};
    nxt_st.sync_sync[0] = {sync_pos_in, sync_neg_in};
    nxt_st.sync_sync[1] = st_ff.sync_sync[0];
    // Level of the crossed differential pair, kept to find its rising edge.
    nxt_st.sync_prev    = st_ff.sync_sync[1][1] & ~st_ff.sync_sync[1][0];

    // Register writes; unmapped addresses are ignored.
    if (reg_req.wr) begin
      case (reg_req.addr)
        `ADDR_CONTROL: begin
          nxt_st.test_en = reg_req.wdata[`CTRL_TEST_EN_BIT]; // [R6]
        end
        `ADDR_TEST_PATTERN: begin
          nxt_st.pattern_kind_sel = reg_req.wdata[`TP_KIND_BIT]; // [R2]
          nxt_st.flash_period_sel = reg_req.wdata[`TP_FLASH_LSB +: 2]; // [R3]
        end
        `ADDR_STARTUP_DELAY: begin
          // Code zero is accepted even with reset mode set; the host must avoid it.
          nxt_st.startup_delay = reg_req.wdata[3:0]; // [R11]
        end
        `ADDR_BANK_SELECT: begin
          nxt_st.bank_sel = reg_req.wdata[2:0];
        end
        `ADDR_BANK_FIRST: begin
          // With no core selected the banked write is dropped.
          if (bank_idx[2]) begin
            nxt_st.bank_regs[bank_idx[1:0]] = reg_req.wdata; // [R17]
          end
        end
        default: begin
          // Unmapped address: nothing is stored.
        end
      endcase
    end

    // Register reads, captured one cycle after the strobe; unused bits read zero.
    if (reg_req.rd) begin
      case (reg_req.addr)
        `ADDR_CONTROL:       nxt_st.rdata = 16'(st_ff.test_en) << `CTRL_TEST_EN_BIT;
        `ADDR_TEST_PATTERN:  nxt_st.rdata = {13'h0000, st_ff.flash_period_sel,
                                             st_ff.pattern_kind_sel};
        `ADDR_STARTUP_DELAY: nxt_st.rdata = {12'h000, st_ff.startup_delay};
        `ADDR_BANK_SELECT:   nxt_st.rdata = {13'h0000, st_ff.bank_sel};
        `ADDR_BANK_FIRST: begin
          nxt_st.rdata = bank_idx[2] ? st_ff.bank_regs[bank_idx[1:0]] : 16'h0000; // [R17]
        end
        default:             nxt_st.rdata = 16'h0000;
      endcase
    end

    // Start-up sequencer driven by the converter master reset.
    // The delay field is sampled as that reset leaves, so a later write waits for the next one.
    case (st_ff.state)
      ST_RESET: begin
        if (!st_ff.adc_rst_sync[1]) begin
          nxt_st.delay_cnt = st_ff.startup_delay;
          nxt_st.state     = (st_ff.startup_delay == 4'h0) ? ST_RUN : ST_DELAY; // [R11]
        end
      end
      ST_DELAY: begin
        // One extra clock per unit of the delay field.
        nxt_st.delay_cnt = st_ff.delay_cnt - 4'h1; // [R11]
        if (st_ff.delay_cnt == 4'h1) begin
          nxt_st.state = ST_RUN;
        end
      end
      ST_RUN: begin
        // Pattern and output generation below.
      end
      default: begin
        nxt_st.state = ST_RESET;
      end
    endcase
    if (st_ff.adc_rst_sync[1]) begin
      nxt_st.state = ST_RESET;
    end

    // Pattern counters run only once started; a sync edge realigns them.
    // Both counters keep running whatever the kind, so switching kinds never stalls them.
    if (st_ff.state == ST_RUN) begin
      if (sync_rise) begin
        nxt_st.ramp      = 11'h000; // [R7]
        nxt_st.flash_cnt = 4'h0;
      end else begin
        nxt_st.ramp      = st_ff.ramp + 11'h001; // [R10]
        nxt_st.flash_cnt = (st_ff.flash_cnt == flash_end) ? 4'h0 : st_ff.flash_cnt + 4'h1; // [R4]
      end
    end

    // Output words: test pattern on every core when enabled, else the samples.
    // Outside the run state they freeze while test output is enabled, which keeps the ramp at its last value.
    if (st_ff.state == ST_RUN) begin
      for (int i = 0; i < 4; i++) begin
        nxt_st.samples[i] = st_ff.test_en ? pattern : conv_words[i]; // [R1] [R6]
      end
    end else if (!st_ff.test_en) begin
      nxt_st.samples = conv_words;
    end // [R9]
  end

  // The single state register; sample outputs reset to zero only on power-up reset.
  // The master reset synchronizer starts out asserted, so the sequencer stays idle
  // until the pin has been seen low through both stages.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff                  <= '0;
      st_ff.pattern_kind_sel <= `RST_PATTERN_KIND;  // [R5]
      st_ff.flash_period_sel <= `RST_FLASH_SEL;     // [R5]
      st_ff.startup_delay    <= `RST_STARTUP_DELAY; // [R11]
      st_ff.bank_sel         <= `RST_BANK_SELECT;   // [R14]
      st_ff.adc_rst_sync     <= 2'h3;
      st_ff.state            <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // One flag per core, set while that core's bank is selected.
  for (genvar g = 0; g < 4; g++) begin : g_core_flag
    assign core_selected[g] = bank_idx[2] & (bank_idx[1:0] == 2'(g));
  end

  // Data outputs come straight from the state register, so no input reaches them
  // through logic; the selection flags and start-up flag are decodes of that register.
  assign out_words  = st_ff.samples;
  assign reg_rdata  = st_ff.rdata;
  assign started_up = (st_ff.state == ST_RUN);

  // Reset mode only constrains what the host may program; no logic uses it.
  logic unused_reset_mode;
  assign unused_reset_mode = reset_mode_flag; // [R12]

endmodule // adc_test_pattern_and_channel_select

// [test/adc_tp_assertions.sv]
module adc_tp_assertions
  import adc_tp_pkg::*;
(
  // Ports of the block; sync pins, reset mode and converted samples are not watched.
  input wire logic        clk,
  input wire logic        reset_n,
  input wire reg_req_t    reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic        adc_reset_in,
  input wire core_words_t out_words,
  input wire logic [3:0]  core_selected,
  input wire logic        started_up
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow of test enable and pattern kind, since neither reaches a port.
  logic te_ff;
  logic kind_ff;
  wire logic run = te_ff && started_up;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      te_ff <= 1'b0;
      kind_ff <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == 5'h01) begin
      te_ff <= reg_req.wdata[12];
    end else if (reg_req.wr && reg_req.addr == 5'h05) begin
      kind_ff <= reg_req.wdata[0];
    end
  end
  // Undefined selector codes map to no core.
  function automatic logic [3:0] sel_of(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? 4'(4'h1 << (c - 3'h1)) : 4'h0;
  endfunction
  // Three running cycles, so the output register has caught up with the mode.
  sequence ramp_on; (run && !kind_ff) [*3]; endsequence
  sequence flash_hi; (run && kind_ff) [*2] ##0 out_words[0] == 11'h7FF; endsequence
  a_cores_same: assert property (
    run [*2] |-> out_words == {4{out_words[0]}}) else $error("Cores differ.");
  a_ramp_step: assert property (
    ramp_on |-> out_words[0] == 11'($past(out_words[0]) + 11'h1) || out_words[0] == 11'h0)
    else $error("Ramp step wrong.");
  a_flash_val: assert property (
    (run && kind_ff) [*3] |-> out_words[0] inside {11'h0, 11'h7FF}) else $error("Flash word.");
  a_flash_gap: assert property (
    flash_hi ##1 (run && kind_ff) |-> out_words[0] == 11'h0) else $error("No zero after ones.");
  a_sel_map: assert property (
    reg_req.wr && reg_req.addr == 5'h0F |=> core_selected == sel_of($past(reg_req.wdata[2:0])))
    else $error("Core select wrong.");
  a_bank_none: assert property (
    reg_req.rd && reg_req.addr == 5'h10 && core_selected == 4'h0 |=> reg_rdata == 16'h0)
    else $error("Bank read without core.");
  a_rst_freeze: assert property (
    (te_ff && adc_reset_in) [*5] |-> $stable(out_words)) else $error("Output moved in reset.");
  a_rst_hold: assert property (
    adc_reset_in [*4] |-> !started_up) else $error("Running during reset.");
endmodule // adc_tp_assertions

// [test/serial_host_model.sv]
module serial_host_model
  import adc_tp_pkg::*;
(
  // Clock, reset-mode flag and observed read data.
  input wire logic        clk,
  input wire logic        reset_mode_flag,
  input wire logic [15:0] reg_rdata,
  // Requests and sync pins driven by the host.
  output     reg_req_t    reg_req,
  output     logic        sync_pos_in,
  output     logic        sync_neg_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus and idle sync level before the first request.
  initial begin
    reg_req = '0;
    sync_pos_in = 1'b0;
    sync_neg_in = 1'b1;
  end
  // Released fields carry inverted junk so stale data is never mistaken for valid.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == 5'h06 && reset_mode_flag && d[3:0] == 4'h0) d[3:0] = 4'h1;
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
    // One more edge, so the stored value has settled when the caller looks at it.
    @(posedge clk);
  endtask
  // Read data is registered at the strobe edge, so it is taken one edge later.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    @(posedge clk);
    d = reg_rdata;
  endtask
  // Sync pulse that realigns the pattern on its rising edge.
  task automatic sync_pulse();
    @(posedge clk);
    sync_pos_in <= 1'b1;
    sync_neg_in <= 1'b0;
    repeat (4) @(posedge clk);
    sync_pos_in <= 1'b0;
    sync_neg_in <= 1'b1;
  endtask
endmodule // serial_host_model

// [test/test_adc_test_pattern_and_channel_select.sv]
module test_adc_test_pattern_and_channel_select
  import adc_tp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic adc_reset_in = 1'b0;
  logic reset_mode_flag = 1'b0;
  reg_req_t reg_req;
  logic [15:0] reg_rdata, d;
  logic [15:0] bv [8];
  core_words_t conv_words = '0, out_words, expw;
  logic [3:0] core_selected;
  logic started_up, sync_pos_in, sync_neg_in;
  int n_fail = 0, checks_done = 0, cyc, base;
  int dl [3] = '{0, 5, 15};
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
  always #5 clk = ~clk;
  adc_test_pattern_and_channel_select u_dut (.clk, .reset_n, .reg_req, .reg_rdata,
    .adc_reset_in, .sync_pos_in, .sync_neg_in, .reset_mode_flag, .conv_words, .out_words,
    .core_selected, .started_up);
  serial_host_model u_host (.clk, .reset_mode_flag, .reg_rdata, .reg_req, .sync_pos_in,
    .sync_neg_in);
  function automatic logic [3:0] sel_exp(input int c);
    return (c >= 1 && c <= 4) ? 4'(1 << (c - 1)) : 4'h0;
  endfunction
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One settled cycle; a wait that outruns its bound ends the run.
  task automatic step(input int lim);
    @(posedge clk);
    #1;
    cyc++;
    if (cyc > lim) begin
      n_fail++;
      $display("Error wait bound %0d exceeded", lim);
      end_of_test();
    end
  endtask
  initial begin
    void'($urandom(32'h738bb854));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    u_host.rd(5'h05, d);
    `CHK("pattern reg", 16'h0, d)
    u_host.rd(5'h06, d);
    `CHK("delay reg", 16'h0, d)
    $display("Reset values done.");
    // Flash kind chosen but test output off: samples must pass through.
    u_host.wr(5'h05, 16'h0001);
    repeat (20) begin
      @(posedge clk);
      expw = conv_words;
      conv_words <= 44'({$urandom(), $urandom()});
      #1;
      `CHK("pass", expw, out_words)
    end
    u_host.wr(5'h01, 16'h1000);
    u_host.wr(5'h05, 16'h0000);
    u_host.sync_pulse();
    // The sync edge restarts the ramp, so word zero stands just as the pulse ends.
    #1;
    cyc = 0;
    while (out_words[0] !== 11'h0) step(2100);
    for (int k = 1; k < 2100; k++) begin
      step(1 << 30);
      `CHK("ramp", {4{11'(k)}}, out_words)
    end
    $display("Ramp done.");
    // Start-up delay is judged relative to code zero, so sync latency cancels.
    foreach (dl[i]) begin
      u_host.wr(5'h06, 16'(dl[i]));
      adc_reset_in <= 1'b1;
      repeat (6) @(posedge clk);
      adc_reset_in <= 1'b0;
      cyc = 0;
      while (started_up !== 1'b1) step(100);
      if (i == 0) base = cyc;
      `CHK("startup", dl[i], cyc - base)
    end
    $display("Delay done.");
    for (int c = 0; c < 4; c++) begin
      u_host.wr(5'h05, 16'((c << 1) | 1));
      #1;
      cyc = 0;
      while (out_words[0] !== 11'h7FF) step(40);
      `CHK("flash word", {4{11'h7FF}}, out_words)
      cyc = 0;
      do step(40); while (out_words[0] !== 11'h7FF);
      `CHK("flash period", (c == 1) ? 12 : (c == 2) ? 16 : 11, cyc)
    end
    $display("Flash done.");
    foreach (bv[c]) begin
      bv[c] = 16'($urandom());
      u_host.wr(5'h0F, 16'(c));
      `CHK("select", sel_exp(c), core_selected)
      u_host.wr(5'h10, bv[c]);
      u_host.rd(5'h10, d);
      `CHK("bank", (sel_exp(c) != 4'h0) ? bv[c] : 16'h0, d)
    end
    for (int c = 1; c < 5; c++) begin
      u_host.wr(5'h0F, 16'(c));
      u_host.rd(5'h10, d);
      `CHK("bank keep", bv[c], d)
    end
    $display("Select done.");
    end_of_test();
  end
endmodule // test_adc_test_pattern_and_channel_select
bind adc_test_pattern_and_channel_select adc_tp_assertions u_chk (.clk, .reset_n, .reg_req,
  .reg_rdata, .adc_reset_in, .out_words, .core_selected, .started_up);
